// [rtl/sadc_defines.svh]
// Timing counts and reset values for the converter sequencing and readout block.
// Assumes a 250 MHz core clock; included by the shifter and core design files.
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH

`define SADC_CLK_MHZ        250
`define SADC_CONV_NS        7000
`define SADC_ACQ_NS         2000
`define SADC_CONV_CYC       ((`SADC_CONV_NS * `SADC_CLK_MHZ) / 1000)
`define SADC_ACQ_CYC        ((`SADC_ACQ_NS * `SADC_CLK_MHZ) / 1000)
`define SADC_SCLK_DIV       8
`define SADC_BITS           16
`define SADC_OVR_CYC        4
`define SADC_RESULT_RST     16'h0000

`endif

// [rtl/sadc_pkg.sv]
// Types shared by the converter sequencing and readout block.
// Assumes sadc_defines.svh is compiled alongside.
package sadc_pkg;

    typedef enum logic [1:0]
    {
        SADC_IDLE = 2'b00,
        SADC_CONV = 2'b01,
        SADC_SHIP = 2'b10,
        SADC_ACQ  = 2'b11
    } sadc_state_e;

    typedef struct packed
    {
        logic coding_select;
        logic interface_select;
        logic byte_order_select;
        logic clock_source_select;
        logic sclk_invert;
        logic sync_invert;
    } sadc_cfg_s;

    typedef struct packed
    {
        logic [15:0] d_out;
        logic [15:0] d_oe;
    } sadc_bus_s;

endpackage

// [rtl/sadc_sync.sv]
// Two-flip-flop synchroniser for one level from outside the core clock domain.
// Assumes the input may change at any time relative to core_clk.
`timescale 1ns/10ps
module sadc_sync
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic srst,
    // Level
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// [rtl/sadc_shifter.sv]
// Sixteen-bit MSB-first output shifter with daisy-chain fill.
// Assumes load and shift never coincide with meaningful intent; load wins.
`timescale 1ns/10ps
`include "sadc_defines.svh"
module sadc_shifter
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // Control
    input  wire logic        load,
    input  wire logic [15:0] load_word,
    input  wire logic        shift,
    input  wire logic        chain_bit,
    // Output
    output logic             msb
);
    logic [15:0] sr_q;

    always_ff @(posedge core_clk)
    begin
        if (srst)
            sr_q <= `SADC_RESULT_RST;
        else if (load)
            sr_q <= load_word;
        else if (shift)
            sr_q <= {sr_q[14:0], chain_bit};
    end

    assign msb = sr_q[15];
endmodule

// [rtl/sadc_core.sv]
// Conversion sequencing with parallel and serial result readout.
// Assumes all pin inputs are asynchronous; the analog result word arrives on adc_result.
`timescale 1ns/10ps
`include "sadc_defines.svh"
// Function
// R01 - Convert start begins a conversion that cannot be aborted or restarted.
// R02 - Convert start held low at busy low auto-starts after internal acquisition.
// R03 - Host pulses convert start low once after power-up to begin.
// R04 - Automatic back-to-back mode may exceed the guaranteed sample rate slightly.
// R05 - Chip select ORed with read; either high releases all interface outputs.
// R06 - Coding select picks two's complement or straight binary result.
// R07 - Interface select low chooses parallel, high chooses serial on shared pins.
// R08 - Parallel result readable after conversion and during the next conversion.
// R09 - Host limits parallel reads during conversion to its first half.
// R10 - Byte order low puts low byte on D[7:0]; high swaps lanes.
// R11 - Serial mode shifts sixteen bits out MSB first, one per clock.
// R12 - Each serial bit stays valid across both edges of its clock.
// R13 - Clock source select low makes the device generate the serial clock.
// R14 - Master mode drives a sync output marking valid serial data.
// R15 - Master serial clock and sync polarity are invertible.
// R16 - Read timing input picks read after or during conversion in master.
// R17 - Master read after conversion holds busy until sixteen bits leave.
// R18 - Master read during conversion keeps clock edges off late decisions.
// R19 - Slave mode takes host clock, shifting only with chip select and read low.
// R20 - Slave accepts continuous or discontinuous clock idling high or low.
// R21 - Host clock should not toggle in the second half of busy high.
// R22 - Slave read during conversion pulses overrun if sixteen bits unread.
// R23 - Slave read after conversion samples chain input on the opposite edge.
// R24 - Busy high from conversion start until the result is available.
module sadc_core
    import sadc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // Conversion control pins
    input  wire logic        convert_start_n,
    input  wire logic        power_down_in,
    output logic             busy,
    // Analog result from the converter array
    input  wire logic [15:0] adc_result,
    // Configuration pins
    input  wire logic        coding_select,
    input  wire logic        interface_select,
    input  wire logic        byte_order_select,
    input  wire logic        clock_source_select,
    input  wire logic        sclk_invert,
    input  wire logic        sync_invert,
    input  wire logic        read_timing_chain_in,
    // Interface strobes
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    // Parallel bus
    output logic [15:0]      data_out,
    output logic [15:0]      data_oe,
    // Serial link
    input  wire logic        sclk_in,
    output logic             sclk_out,
    output logic             sclk_oe,
    output logic             serial_data_out,
    output logic             serial_data_oe,
    output logic             sync_out,
    output logic             sync_oe,
    output logic             read_overrun_flag,
    // Power state
    output logic             powered_down
);
    localparam logic [15:0] CONV_CYC = 16'(`SADC_CONV_CYC);
    localparam logic [15:0] ACQ_CYC  = 16'(`SADC_ACQ_CYC);
    localparam logic [3:0]  DIV_LAST = 4'(`SADC_SCLK_DIV - 1);
    localparam logic [4:0]  NBITS    = 5'(`SADC_BITS);
    localparam logic [2:0]  OVR_LAST = 3'(`SADC_OVR_CYC - 1);

    // Synchronised pins.
    logic       cnv_n_s;
    logic       pd_s;
    logic       cs_s;
    logic       rd_s;
    logic       sclk_s;
    logic       chain_s;
    sadc_cfg_s  cfg_raw;
    sadc_cfg_s  cfg;

    assign cfg_raw = '{coding_select, interface_select, byte_order_select,
                       clock_source_select, sclk_invert, sync_invert};

    sadc_sync u_sync_cnv  (.core_clk(core_clk), .srst(srst), .async_in(convert_start_n),
                           .sync_out(cnv_n_s));
    sadc_sync u_sync_pd   (.core_clk(core_clk), .srst(srst), .async_in(power_down_in),
                           .sync_out(pd_s));
    // Strobes pass inverted so a flushed synchroniser means deselected, not selected.
    sadc_sync u_sync_cs   (.core_clk(core_clk), .srst(srst), .async_in(~cs_n),
                           .sync_out(cs_s));
    sadc_sync u_sync_rd   (.core_clk(core_clk), .srst(srst), .async_in(~rd_n),
                           .sync_out(rd_s));
    sadc_sync u_sync_sclk (.core_clk(core_clk), .srst(srst), .async_in(sclk_in),
                           .sync_out(sclk_s));
    sadc_sync u_sync_chn  (.core_clk(core_clk), .srst(srst), .async_in(read_timing_chain_in),
                           .sync_out(chain_s));

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_cfg
            sadc_sync u_sync_cfg (.core_clk(core_clk), .srst(srst), .async_in(cfg_raw[gi]),
                                  .sync_out(cfg[gi]));
        end
    endgenerate

    // Start edge detection on the synchronised level.
    // The edge register resets low so the flushed synchroniser cannot fake a start.
    logic cnv_n_q;
    logic start_fall;

    always_ff @(posedge core_clk)
    begin
        if (srst)
            cnv_n_q <= 1'b0;
        else
            cnv_n_q <= cnv_n_s;
    end

    assign start_fall = cnv_n_q & ~cnv_n_s;

    // Serial mode decode.
    logic ser_mode;
    logic master;
    logic rd_after;
    logic sel;

    assign ser_mode = cfg.interface_select;
    assign master   = ser_mode & ~cfg.clock_source_select;
    assign rd_after = ~chain_s;
    assign sel      = cs_s & rd_s; // R05

    // Conversion sequencer.
    sadc_state_e state_q;
    logic [15:0] tmr_q;
    logic [4:0]  bits_left_q;
    logic        conv_done;
    logic        ship_needed;

    assign conv_done   = (state_q == SADC_CONV) && (tmr_q == CONV_CYC - 16'h0001);
    assign ship_needed = master & rd_after; // R17

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_q <= SADC_IDLE;
            tmr_q   <= 16'h0000;
        end
        else
        begin
            case (state_q)
                SADC_IDLE:
                begin
                    tmr_q <= 16'h0000;
                    if (start_fall && !pd_s) // R01
                        state_q <= SADC_CONV;
                end
                SADC_CONV:
                begin
                    // Power-down and further start edges are ignored here on purpose.
                    tmr_q <= tmr_q + 16'h0001; // R01
                    if (conv_done)
                    begin
                        tmr_q   <= 16'h0000;
                        state_q <= ship_needed ? SADC_SHIP : SADC_ACQ;
                    end
                end
                SADC_SHIP:
                begin
                    if (bits_left_q == 5'h00) // R17
                        state_q <= SADC_ACQ;
                end
                SADC_ACQ:
                begin
                    tmr_q <= tmr_q + 16'h0001;
                    if (start_fall && !pd_s)
                    begin
                        tmr_q   <= 16'h0000;
                        state_q <= SADC_CONV;
                    end
                    else if (tmr_q >= ACQ_CYC - 16'h0001)
                    begin
                        // Held-low start restarts after the timed acquisition. R02 R04
                        tmr_q   <= 16'h0000;
                        state_q <= (!cnv_n_s && !pd_s) ? SADC_CONV : SADC_IDLE;
                    end
                end
                default:
                    state_q <= SADC_IDLE;
            endcase
        end
    end

    assign busy         = (state_q == SADC_CONV) || (state_q == SADC_SHIP); // R24
    assign powered_down = pd_s && !busy;

    // Result capture with output coding.
    logic [15:0] result_q;
    logic        new_result;

    assign new_result = conv_done;

    always_ff @(posedge core_clk)
    begin
        if (srst)
            result_q <= `SADC_RESULT_RST;
        else if (new_result)
            result_q <= cfg.coding_select ? adc_result : {~adc_result[15], adc_result[14:0]}; // R06
    end

    // Parallel bus. The latched result stays readable through the next conversion. R08
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            data_out <= 16'h0000;
            data_oe  <= 16'h0000;
        end
        else
        begin
            data_out <= cfg.byte_order_select ? {result_q[7:0], result_q[15:8]} : result_q; // R10
            data_oe  <= (sel && !ser_mode) ? 16'hffff : 16'h0000; // R05 R07
        end
    end

    // Master clock divider gives one enable pulse per half period.
    logic [3:0] div_q;
    logic       half_tick;
    logic       msclk_q;
    logic       mactive_q;
    logic       conv_early;

    assign half_tick  = (div_q == DIV_LAST);
    // Only the first half of the conversion is used for master read-during shifting. R18
    assign conv_early = (state_q == SADC_CONV) && (tmr_q < (CONV_CYC >> 1));

    always_ff @(posedge core_clk)
    begin
        if (srst)
            div_q <= 4'h0;
        else
            div_q <= half_tick ? 4'h0 : div_q + 4'h1;
    end

    // Slave clock edge detection on the synchronised host clock.
    logic sclk_prev_q;
    logic s_rise;
    logic s_fall;

    always_ff @(posedge core_clk)
    begin
        if (srst)
            sclk_prev_q <= 1'b0;
        else
            sclk_prev_q <= sclk_s;
    end

    assign s_rise = sclk_s & ~sclk_prev_q;
    assign s_fall = ~sclk_s & sclk_prev_q;

    // Shift scheduling. Data changes on falling clock and is stable across the rising edge
    // and the following fall, so the host may capture on either. R12 R20
    logic        load_sr;
    logic        shift_sr;
    logic        serial_bit;
    logic        chain_q;
    logic        m_fall;
    logic        m_go;
    logic        during_q;

    assign m_go     = mactive_q && half_tick;
    assign m_fall   = m_go && msclk_q;
    assign load_sr  = ser_mode && (new_result ? rd_after
                                   : (start_fall && state_q != SADC_CONV && !rd_after));
    assign shift_sr = (master ? m_fall : (sel && s_fall)) && bits_left_q != 5'h00; // R11 R19

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            bits_left_q <= 5'h00;
            during_q    <= 1'b0;
        end
        else if (load_sr)
        begin
            bits_left_q <= NBITS;
            during_q    <= !rd_after;
        end
        else if (shift_sr)
            bits_left_q <= bits_left_q - 5'h01;
    end

    // Daisy-chain bit latched on the rising edge, opposite to the shifting fall. R23
    always_ff @(posedge core_clk)
    begin
        if (srst)
            chain_q <= 1'b0;
        else if (sel && s_rise && rd_after && !master)
            chain_q <= chain_s;
    end

    sadc_shifter u_shift
    (
        .core_clk  (core_clk),
        .srst      (srst),
        .load      (load_sr),
        .load_word (new_result ? (cfg.coding_select ? adc_result
                                 : {~adc_result[15], adc_result[14:0]}) : result_q),
        .shift     (shift_sr),
        .chain_bit (chain_q),
        .msb       (serial_bit)
    );

    // Master clock generation; runs only while bits remain. R13 R16 R18
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            msclk_q   <= 1'b0;
            mactive_q <= 1'b0;
        end
        else if (!master || bits_left_q == 5'h00)
        begin
            msclk_q   <= 1'b0;
            mactive_q <= 1'b0;
        end
        else
        begin
            mactive_q <= during_q ? conv_early : 1'b1;
            if (m_go)
                msclk_q <= ~msclk_q;
        end
    end

    // Read overrun pulse when a slave read-during conversion ends with unread bits. R22
    logic [2:0] ovr_q;

    always_ff @(posedge core_clk)
    begin
        if (srst)
            ovr_q <= 3'h0;
        else if (conv_done && !master && ser_mode && during_q && bits_left_q != 5'h00)
            ovr_q <= OVR_LAST + 3'h1;
        else if (ovr_q != 3'h0)
            ovr_q <= ovr_q - 3'h1;
    end

    assign read_overrun_flag = (ovr_q != 3'h0);

    // Serial pin drive, released whenever chip select or read is high. R05 R07
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            serial_data_out <= 1'b0;
            serial_data_oe  <= 1'b0;
            sclk_out        <= 1'b0;
            sclk_oe         <= 1'b0;
            sync_out        <= 1'b0;
            sync_oe         <= 1'b0;
        end
        else
        begin
            serial_data_out <= serial_bit; // R11
            serial_data_oe  <= sel && ser_mode;
            sclk_out        <= msclk_q ^ cfg.sclk_invert; // R15
            sclk_oe         <= sel && master; // R13
            sync_out        <= (mactive_q && bits_left_q != 5'h00) ^ cfg.sync_invert; // R14 R15
            sync_oe         <= sel && master;
        end
    end
endmodule

// [testbench/sadc_core_checker.sv]
// Pin-level assertions for the converter sequencing and readout block.
// Assumes configuration pins stay steady for several cycles around each check.
`timescale 1ns/10ps
module sadc_core_checker
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        srst,
    // Pins watched
    input wire logic        convert_start_n,
    input wire logic        power_down_in,
    input wire logic        busy,
    input wire logic        interface_select,
    input wire logic        clock_source_select,
    input wire logic        read_timing_chain_in,
    input wire logic        cs_n,
    input wire logic        rd_n,
    input wire logic [15:0] data_oe,
    input wire logic        serial_data_oe,
    input wire logic        sync_oe,
    input wire logic        sclk_oe,
    input wire logic        read_overrun_flag
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (srst);

    logic [11:0] busy_cnt_q;

    // Counts each busy interval so its length can be judged when it ends.
    always_ff @(posedge core_clk)
    begin
        if (srst || !busy)
            busy_cnt_q <= 12'h000;
        else
            busy_cnt_q <= busy_cnt_q + 12'h001;
    end

    a_start_busy:
        assert property ($fell(convert_start_n) && !busy && !power_down_in |-> ##[1:8] busy)
        else $error("busy did not follow a convert start");
    a_no_abort:
        assert property ($fell(busy) |-> busy_cnt_q >= 12'h6d4)
        else $error("conversion ended early");
    a_conv_len:
        assert property ($fell(busy) && !interface_select |-> busy_cnt_q <= 12'h6d8)
        else $error("busy too long in parallel mode");
    a_ship_busy:
        assert property ($fell(busy) && interface_select && !clock_source_select
                         && !read_timing_chain_in |-> busy_cnt_q >= 12'h79e)
        else $error("busy fell before the bits left");
    a_oe_off:
        assert property ((cs_n || rd_n) [*5] |->
                         data_oe == 16'h0000 && !serial_data_oe && !sync_oe)
        else $error("outputs driven while deselected");
    a_par_oe:
        assert property ((!cs_n && !rd_n && !interface_select) [*5] |-> data_oe == 16'hffff)
        else $error("parallel bus not driven");
    a_ser_nopar:
        assert property (interface_select [*5] |-> data_oe == 16'h0000)
        else $error("parallel bus driven in serial mode");
    a_ovr_pulse:
        assert property ($rose(read_overrun_flag) |-> read_overrun_flag [*4] ##1 !read_overrun_flag)
        else $error("overrun pulse length wrong");
    a_slave_clk:
        assert property (clock_source_select [*5] |-> !sclk_oe)
        else $error("serial clock driven in slave mode");

    c_conv: cover property ($rose(busy));
    c_ovr: cover property ($rose(read_overrun_flag));
    c_par: cover property (data_oe == 16'hffff);
endmodule

// [testbench/sadc_host_model.sv]
// Host side of the serial link: burst clock maker and bit collector.
// Assumes the bench clears it before each readout and waits out each burst.
`timescale 1ns/10ps
module sadc_host_model
(
    // Clock and control
    input wire logic        core_clk,
    input wire logic        clr,
    input wire logic        burst,
    input wire logic        master,
    // Link
    input wire logic        sclk_out,
    input wire logic        serial_data_out,
    output logic            sclk_in,
    // Collected result
    output logic [15:0]     word,
    output logic [4:0]      nbits
);
    logic clk_q = 1'b0;

    initial sclk_in = 1'b0;
    initial word = 16'h0000;
    initial nbits = 5'h00;

    // The clock stands low between bursts; the bench bursts after a conversion or early in one.
    always @(posedge burst)
    begin
        #1.3;
        repeat (16)
        begin
            #24 sclk_in = 1'b1;
            #24 sclk_in = 1'b0;
        end
    end

    // Bits are taken on the rising clock, which the device holds them across.
    always @(posedge core_clk)
    begin
        clk_q <= master ? sclk_out : sclk_in;
        if (clr)
        begin
            word <= 16'h0000;
            nbits <= 5'h00;
        end
        else if ((master ? sclk_out : sclk_in) && !clk_q)
        begin
            word <= {word[14:0], serial_data_out};
            nbits <= nbits + 5'h01;
        end
    end
endmodule

// [testbench/sadc_core_tb_top.sv]
// Self-checking bench for the converter sequencing and readout block.
// Assumes the host model sits on the serial pins and the checker is bound in.
`timescale 1ns/10ps
module sadc_core_tb_top;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic        convert_start_n = 1'b1;
    logic        power_down_in = 1'b0;
    logic [15:0] adc_result = 16'h0000;
    logic        coding_select = 1'b1;
    logic        interface_select = 1'b0;
    logic        byte_order_select = 1'b0;
    logic        clock_source_select = 1'b0;
    logic        sclk_invert = 1'b0;
    logic        sync_invert = 1'b0;
    logic        read_timing_chain_in = 1'b0;
    logic        cs_n = 1'b1;
    logic        rd_n = 1'b1;
    logic        clr = 1'b0;
    logic        burst = 1'b0;
    logic        busy, sclk_in, sclk_out, sclk_oe, serial_data_out, serial_data_oe;
    logic        sync_out, sync_oe, read_overrun_flag, powered_down;
    logic [15:0] data_out, data_oe, word;
    logic [4:0]  nbits;
    logic        sync_drv = 1'b0;
    logic        sclk_drv = 1'b0;
    logic        ovr_seen = 1'b0;
    int          err_count = 0;
    int          total_checks = 0;
    int          cyc_q = 0;

    sadc_core dut (.core_clk, .srst, .convert_start_n, .power_down_in, .busy, .adc_result,
        .coding_select, .interface_select, .byte_order_select, .clock_source_select,
        .sclk_invert, .sync_invert, .read_timing_chain_in, .cs_n, .rd_n, .data_out,
        .data_oe, .sclk_in, .sclk_out, .sclk_oe, .serial_data_out, .serial_data_oe,
        .sync_out, .sync_oe, .read_overrun_flag, .powered_down);
    sadc_host_model host (.core_clk, .clr, .burst, .master(!clock_source_select),
        .sclk_out, .serial_data_out(serial_data_oe ? serial_data_out : ~serial_data_out),
        .sclk_in, .word, .nbits);

    always #2 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        cyc_q <= cyc_q + 1;
        if (sync_oe === 1'b1)
            sync_drv = 1'b1;
        if (sclk_oe === 1'b1)
            sclk_drv = 1'b1;
        if (read_overrun_flag === 1'b1)
            ovr_seen = 1'b1;
        if (cyc_q == 60000)
        begin
            err_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wait_lvl(input logic lvl, output int n);
        n = 0;
        while (busy !== lvl && n < 4000)
        begin
            @(posedge core_clk);
            n++;
        end
        if (busy !== lvl)
        begin
            err_count++;
            $display("MISMATCH busy wait expected %b seen %b", lvl, busy);
        end
    endtask

    task automatic start();
        convert_start_n <= 1'b0;
        tick(4);
        convert_start_n <= 1'b1;
    endtask

    task automatic conv(output int w);
        int n;
        start();
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, w);
    endtask

    task automatic read_burst();
        clr <= 1'b1;
        tick(2);
        clr <= 1'b0;
        burst <= 1'b1;
        tick(2);
        burst <= 1'b0;
        tick(220);
    endtask

    task automatic t_parallel();
        int k;
        int w;
        logic [15:0] exp;
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        for (k = 0; k < 3; k++)
        begin
            coding_select <= (k != 1);
            byte_order_select <= (k == 2);
            adc_result <= 16'h8a5c;
            conv(w);
            check("busy width", 16'h0001, {15'h0000, w >= 1748 && w <= 1752});
            tick(6);
            exp = (k == 1) ? 16'h0a5c : (k == 2) ? 16'h5c8a : 16'h8a5c;
            check("parallel data", exp, data_out);
        end
        adc_result <= 16'h3c1e;
        start();
        tick(300);
        check("data in conversion", 16'h5c8a, data_out);
        wait_lvl(1'b0, w);
        cs_n <= 1'b1;
        tick(6);
        check("bus released", 16'h0000, data_oe);
        $display("parallel test done");
    endtask

    task automatic t_power();
        int w;
        start();
        tick(20);
        power_down_in <= 1'b1;
        wait_lvl(1'b0, w);
        check("no abort", 16'h0001, {15'h0000, w > 1700});
        start();
        tick(20);
        check("start while down", 16'h0000, {15'h0000, busy});
        check("powered down", 16'h0001, {15'h0000, powered_down});
        power_down_in <= 1'b0;
        tick(5);
        $display("power down test done");
    endtask

    task automatic t_auto();
        int a;
        int b;
        int g;
        convert_start_n <= 1'b0;
        wait_lvl(1'b1, a);
        wait_lvl(1'b0, a);
        wait_lvl(1'b1, g);
        b = a + g;
        check("auto restart", 16'h0001, {15'h0000, g >= 490 && g <= 510 && b <= 2500});
        convert_start_n <= 1'b1;
        wait_lvl(1'b0, a);
        tick(600);
        $display("auto test done");
    endtask

    task automatic t_master();
        int w;
        logic s;
        logic y;
        interface_select <= 1'b1;
        cs_n <= 1'b0;
        coding_select <= 1'b1;
        adc_result <= 16'hb7e1;
        clr <= 1'b1;
        tick(6);
        clr <= 1'b0;
        conv(w);
        check("master busy", 16'h0001, {15'h0000, w >= 1990});
        check("master word", 16'hb7e1, word);
        check("master bits", 16'h0010, {11'h000, nbits});
        check("drives clock and sync", 16'h0003, {14'h0000, sclk_drv, sync_drv});
        s = sclk_out;
        y = sync_out;
        sclk_invert <= 1'b1;
        sync_invert <= 1'b1;
        tick(6);
        check("inverted idle", {14'h0000, ~s, ~y}, {14'h0000, sclk_out, sync_out});
        sclk_invert <= 1'b0;
        sync_invert <= 1'b0;
        read_timing_chain_in <= 1'b1;
        adc_result <= 16'h1111;
        read_burst();
        conv(w);
        check("busy not held", 16'h0001, {15'h0000, w <= 1752});
        check("previous word", 16'hb7e1, word);
        $display("master test done");
    endtask

    task automatic t_slave();
        int w;
        clock_source_select <= 1'b1;
        read_timing_chain_in <= 1'b0;
        adc_result <= 16'h6d2b;
        cs_n <= 1'b1;
        conv(w);
        read_burst();
        cs_n <= 1'b0;
        tick(6);
        read_burst();
        check("slave word", 16'h6d2b, word);
        read_timing_chain_in <= 1'b1;
        tick(6);
        ovr_seen = 1'b0;
        conv(w);
        tick(10);
        check("overrun", 16'h0001, {15'h0000, ovr_seen});
        ovr_seen = 1'b0;
        adc_result <= 16'h4477;
        start();
        tick(30);
        read_burst();
        wait_lvl(1'b0, w);
        tick(10);
        check("read in conversion", 16'h6d2b, word);
        check("no overrun", 16'h0000, {15'h0000, ovr_seen});
        $display("slave test done");
    endtask

    initial
    begin
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        tick(5);
        t_parallel();
        t_power();
        t_auto();
        t_master();
        t_slave();
        give_verdict();
    end
endmodule

bind sadc_core sadc_core_checker u_chk (.core_clk, .srst, .convert_start_n, .power_down_in,
    .busy, .interface_select, .clock_source_select, .read_timing_chain_in, .cs_n, .rd_n,
    .data_oe, .serial_data_oe, .sync_oe, .sclk_oe, .read_overrun_flag);
